// >>> hw/csp_pkg.sv
// Shared constants and types for the pin-control link of the clock synchronizer.
// Assumes a 50 MHz system clock on both ends.
package csp_pkg;

  localparam int CLK_NS     = 20;
  localparam int RST_MIN_NS = 300;
  localparam int RST_CYC    = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

  localparam logic MODE_NORMAL  = 1'b0;
  localparam logic MODE_FREERUN = 1'b1;
  localparam logic [7:0] MODESEL_ADDR = 8'h1f;

  localparam logic [31:0] APLL_DEF_KHZ     = 32'd77760;
  localparam logic [31:0] APLL_MAX_SDH_KHZ = 32'd77760;
  localparam logic [31:0] APLL_MAX_ETH_KHZ = 32'd125000;
  localparam logic [31:0] PCLK_DEF_KHZ     = 32'd2048;
  localparam logic [31:0] PCLK_LOW_KHZ     = 32'd2;
  localparam logic [31:0] PCLK_MAX_KHZ     = 32'd100000;
  localparam int          PCLK_STEP_LOG2   = 3;
  localparam logic [31:0] FP_DEF_HZ        = 32'd8000;
  localparam logic [3:0]  FP_DEF_STYLE     = 4'h0;

  localparam logic [1:0] CFG_APLL  = 2'h0;
  localparam logic [1:0] CFG_PCLK  = 2'h1;
  localparam logic [1:0] CFG_FP    = 2'h2;
  localparam logic [1:0] CFG_STYLE = 2'h3;

  localparam logic [1:0] IR_CAPTURE = 2'h1;

  // Controller registers, byte addresses
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] PINS_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;

  // CTRL fields
  localparam int C_MODE = 0;
  localparam int C_DIFF = 1;
  localparam int C_I2C  = 2;
  localparam int C_RST  = 3;
  localparam int C_TRST = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
  // PINS fields
  localparam int P_SCK  = 0;
  localparam int P_SI   = 1;
  localparam int P_SEL  = 2;
  localparam int P_TCK  = 3;
  localparam int P_TMS  = 4;
  localparam int P_TDI  = 5;
  localparam logic [31:0] PINS_RESET = 32'h0000_0036;
  // STAT fields
  localparam int S_LOCK = 0;
  localparam int S_HOLD = 1;
  localparam int S_INT  = 2;
  localparam int S_SO   = 3;
  localparam int S_SCL  = 4;
  localparam int S_SDA  = 5;
  localparam int S_TDO  = 6;
  localparam int S_BUSY = 7;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_e;

endpackage : csp_pkg

// >>> hw/csp_if.sv
// Board-level pins between the host controller and the synchronizer.
// Resolves the open-drain and shared lines; scl, sda, int_n, so and tdo have pull-ups.
`timescale 1ns/1ps
interface csp_if;
  logic rst_n, mode, diff_en, i2c_en, sel, tck, tms, tdi, trst_n;
  logic scl_h_o, scl_h_oe, sda_h_o, sda_h_oe;
  logic scl_d_o, scl_d_oe, sda_d_o, sda_d_oe;
  logic so_o, so_oe, int_o, int_oe, tdo_o, tdo_oe, lock, hold;
  logic scl, sda, int_n, so, tdo;

  assign scl   = ~((scl_h_oe & ~scl_h_o) | (scl_d_oe & ~scl_d_o));
  assign sda   = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
  assign int_n = ~(int_oe & ~int_o);
  assign so    = so_oe ? so_o : 1'b1;
  assign tdo   = tdo_oe ? tdo_o : 1'b1;

  modport dev (
    input  rst_n, mode, diff_en, i2c_en, sel, tck, tms, tdi, trst_n, scl, sda,
    output scl_d_o, scl_d_oe, sda_d_o, sda_d_oe, so_o, so_oe,
    output int_o, int_oe, tdo_o, tdo_oe, lock, hold
  );
  modport host (
    output rst_n, mode, diff_en, i2c_en, sel, tck, tms, tdi, trst_n,
    output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe,
    input  scl, sda, int_n, so, tdo, lock, hold
  );
endinterface : csp_if

// >>> hw/pin_sync3.sv
// Three-stage input synchronizer with agreement filter.
// Assumes pins are asynchronous to mclk_i.
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } st_s;

  st_s st;
  st_s next_st;

  always_comb begin
    next_st     = st;
    next_st.s1  = pin_i;
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    // A bit changes once stages two and three agree
    next_st.lvl = (st.s2 & ~(st.s2 ^ st.s3)) | (st.lvl & (st.s2 ^ st.s3));
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.lvl;
endmodule : pin_sync3

// >>> hw/sync_dev_pins.sv
// Synchronizer device end: reset, mode, output enable, status, interrupt,
// serial-port pin sharing, synthesizer defaults and the test access port.
// Assumes the link pins come from another clock domain.
//
// Overview of operation
// - Low chip reset puts device in reset
// - Host holds reset low 300 ns minimum
// - Mode pin during reset sets default mode
// - Later mode follows pin or register 0x1F
// - Differential driver enabled only while enable high
// - Lock high only when frequency and phase locked
// - Hold high while in holdover
// - Strap high selects I2C, low SPI
// - Clock pin: SPI input or I2C SCL
// - Data pin: SPI input or I2C SDA
// - Serial output drives only in SPI mode
// - Select pin: SPI chip select or address bit
// - Status change pulls open-drain interrupt low
// - Test data out changes on falling TCK
// - Test data out floats unless scanning
// - Low test reset forces Test-Logic-Reset
// - Host pulses test reset at power-up
// - Analog PLL clock defaults 77.76 MHz
// - Synthesizer clock defaults 2.048 MHz
// - Synthesizer frame pulse defaults 8 kHz
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module sync_dev_pins (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  csp_if.dev               pins,
  input  wire logic        freq_lock_i,
  input  wire logic        phase_lock_i,
  input  wire logic        holdover_i,
  input  wire logic        status_chg_i,
  input  wire logic        isr_read_i,
  input  wire logic        modesel_wr_i,
  input  wire logic        modesel_val_i,
  input  wire logic        ser_dout_i,
  input  wire logic        scl_low_i,
  input  wire logic        sda_low_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [1:0]  cfg_sel_i,
  input  wire logic        cfg_eth_i,
  input  wire logic [31:0] cfg_val_i,
  output logic             dev_rst_o,
  output logic             dpll_mode_o,
  output logic             diff_drv_en_o,
  output logic             i2c_mode_o,
  output logic             ser_clk_o,
  output logic             ser_din_o,
  output logic             spi_cs_n_o,
  output logic             bus_address_bit_zero_o,
  output logic [31:0]      apll_khz_o,
  output logic [31:0]      pclk_khz_o,
  output logic [31:0]      fp_hz_o,
  output logic [3:0]       fp_style_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronizers

  localparam int NS = 11;

  logic [NS-1:0] pin_raw;
  logic [NS-1:0] pin_s;
  logic          rst_n_s;
  logic          mode_s;
  logic          diff_s;
  logic          i2c_s;
  logic          sel_s;
  logic          scl_s;
  logic          sda_s;
  logic          tck_s;
  logic          tms_s;
  logic          tdi_s;
  logic          trst_n_s;

  assign pin_raw = {pins.rst_n, pins.mode, pins.diff_en, pins.i2c_en, pins.sel,
                    pins.scl, pins.sda, pins.tck, pins.tms, pins.tdi, pins.trst_n};

  pin_sync3 #(
    .W    (NS),
    .INIT ('0)
  ) u_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (pin_raw),
    .level_o   (pin_s)
  );

  assign {rst_n_s, mode_s, diff_s, i2c_s, sel_s, scl_s, sda_s,
          tck_s, tms_s, tdi_s, trst_n_s} = pin_s;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic             in_rst;
    logic             mode;
    logic             mode_pin_q;
    logic             diff_en;
    logic             i2c;
    logic             ser_clk;
    logic             ser_din;
    logic             cs_n;
    logic             addr0;
    logic             so;
    logic             so_oe;
    logic             scl_oe;
    logic             sda_oe;
    logic             int_oe;
    logic             lock;
    logic             hold;
    logic [31:0]      apll;
    logic [31:0]      pclk;
    logic [31:0]      fp;
    logic [3:0]       style;
    csp_pkg::tap_e    tap;
    logic             tck_q;
    logic [1:0]       ir;
    logic             byp;
    logic             tdo;
    logic             tdo_oe;
  } st_s;

  st_s st;
  st_s next_st;

  localparam st_s ST_RESET = '{
    in_rst: 1'b1, mode: csp_pkg::MODE_NORMAL, mode_pin_q: 1'b0, diff_en: 1'b0,
    i2c: 1'b0, ser_clk: 1'b0, ser_din: 1'b0, cs_n: 1'b1, addr0: 1'b0,
    so: 1'b0, so_oe: 1'b0, scl_oe: 1'b0, sda_oe: 1'b0, int_oe: 1'b0,
    lock: 1'b0, hold: 1'b0,
    apll: csp_pkg::APLL_DEF_KHZ, pclk: csp_pkg::PCLK_DEF_KHZ,
    fp: csp_pkg::FP_DEF_HZ, style: csp_pkg::FP_DEF_STYLE,
    tap: csp_pkg::TLR, tck_q: 1'b0, ir: csp_pkg::IR_CAPTURE, byp: 1'b0,
    tdo: 1'b0, tdo_oe: 1'b0
  };

  function automatic csp_pkg::tap_e tap_next(input csp_pkg::tap_e s, input logic tms);
    unique case (s)
      csp_pkg::TLR:    tap_next = tms ? csp_pkg::TLR    : csp_pkg::RTI;
      csp_pkg::RTI:    tap_next = tms ? csp_pkg::SEL_DR : csp_pkg::RTI;
      csp_pkg::SEL_DR: tap_next = tms ? csp_pkg::SEL_IR : csp_pkg::CAP_DR;
      csp_pkg::CAP_DR: tap_next = tms ? csp_pkg::EX1_DR : csp_pkg::SH_DR;
      csp_pkg::SH_DR:  tap_next = tms ? csp_pkg::EX1_DR : csp_pkg::SH_DR;
      csp_pkg::EX1_DR: tap_next = tms ? csp_pkg::UPD_DR : csp_pkg::PA_DR;
      csp_pkg::PA_DR:  tap_next = tms ? csp_pkg::EX2_DR : csp_pkg::PA_DR;
      csp_pkg::EX2_DR: tap_next = tms ? csp_pkg::UPD_DR : csp_pkg::SH_DR;
      csp_pkg::UPD_DR: tap_next = tms ? csp_pkg::SEL_DR : csp_pkg::RTI;
      csp_pkg::SEL_IR: tap_next = tms ? csp_pkg::TLR    : csp_pkg::CAP_IR;
      csp_pkg::CAP_IR: tap_next = tms ? csp_pkg::EX1_IR : csp_pkg::SH_IR;
      csp_pkg::SH_IR:  tap_next = tms ? csp_pkg::EX1_IR : csp_pkg::SH_IR;
      csp_pkg::EX1_IR: tap_next = tms ? csp_pkg::UPD_IR : csp_pkg::PA_IR;
      csp_pkg::PA_IR:  tap_next = tms ? csp_pkg::EX2_IR : csp_pkg::PA_IR;
      csp_pkg::EX2_IR: tap_next = tms ? csp_pkg::UPD_IR : csp_pkg::SH_IR;
      csp_pkg::UPD_IR: tap_next = tms ? csp_pkg::SEL_DR : csp_pkg::RTI;
    endcase
  endfunction : tap_next

  logic        tck_rise;
  logic        tck_fall;
  logic        pclk_ok;
  logic [31:0] apll_max;

  assign tck_rise = tck_s & ~st.tck_q;
  assign tck_fall = ~tck_s & st.tck_q;
  assign apll_max = cfg_eth_i ? csp_pkg::APLL_MAX_ETH_KHZ : csp_pkg::APLL_MAX_SDH_KHZ;
  assign pclk_ok  = (cfg_val_i == csp_pkg::PCLK_LOW_KHZ) ||
                    ((cfg_val_i[csp_pkg::PCLK_STEP_LOG2-1:0] == '0) &&
                     (cfg_val_i != '0) && (cfg_val_i <= csp_pkg::PCLK_MAX_KHZ));

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st            = st;
    next_st.in_rst     = ~rst_n_s;
    next_st.mode_pin_q = mode_s;
    if (st.in_rst) begin
      // Last level seen in reset stays as the default
      next_st.mode = mode_s;
    end else if (modesel_wr_i) begin
      next_st.mode = modesel_val_i;
    end else if (mode_s != st.mode_pin_q) begin
      next_st.mode = mode_s;
    end

    next_st.diff_en = diff_s & ~st.in_rst;
    next_st.lock    = freq_lock_i & phase_lock_i & ~st.in_rst;
    next_st.hold    = holdover_i & ~st.in_rst;

    // Serial pin sharing
    next_st.i2c     = i2c_s;
    next_st.ser_clk = scl_s;
    next_st.ser_din = sda_s;
    next_st.cs_n    = i2c_s | sel_s;
    next_st.addr0   = i2c_s & sel_s;
    next_st.scl_oe  = i2c_s & scl_low_i & ~st.in_rst;
    next_st.sda_oe  = i2c_s & sda_low_i & ~st.in_rst;
    next_st.so      = ser_dout_i;
    next_st.so_oe   = ~i2c_s & ~sel_s & ~st.in_rst;

    // Interrupt: new event wins over a service read
    if (st.in_rst) begin
      next_st.int_oe = 1'b0;
    end else if (status_chg_i) begin
      next_st.int_oe = 1'b1;
    end else if (isr_read_i) begin
      next_st.int_oe = 1'b0;
    end

    // Synthesizer settings
    if (st.in_rst) begin
      next_st.apll  = csp_pkg::APLL_DEF_KHZ;
      next_st.pclk  = csp_pkg::PCLK_DEF_KHZ;
      next_st.fp    = csp_pkg::FP_DEF_HZ;
      next_st.style = csp_pkg::FP_DEF_STYLE;
    end else if (cfg_wr_i) begin
      unique case (cfg_sel_i)
        csp_pkg::CFG_APLL: begin
          if (cfg_val_i != '0 && cfg_val_i <= apll_max) begin
            next_st.apll = cfg_val_i;
          end
        end
        csp_pkg::CFG_PCLK: begin
          if (pclk_ok) begin
            next_st.pclk = cfg_val_i;
          end
        end
        csp_pkg::CFG_FP: begin
          if (cfg_val_i != '0) begin
            next_st.fp = cfg_val_i;
          end
        end
        csp_pkg::CFG_STYLE: begin
          next_st.style = cfg_val_i[3:0];
        end
      endcase
    end

    // Test access port
    next_st.tck_q = tck_s;
    if (tck_rise) begin
      next_st.tap = tap_next(st.tap, tms_s);
      unique case (st.tap)
        csp_pkg::CAP_IR: next_st.ir  = csp_pkg::IR_CAPTURE;
        csp_pkg::SH_IR:  next_st.ir  = {tdi_s, st.ir[1]};
        csp_pkg::CAP_DR: next_st.byp = 1'b0;
        csp_pkg::SH_DR:  next_st.byp = tdi_s;
        default:         next_st.ir  = st.ir;
      endcase
    end
    if (tck_fall) begin
      next_st.tdo    = (st.tap == csp_pkg::SH_IR) ? st.ir[0] : st.byp;
      next_st.tdo_oe = (st.tap == csp_pkg::SH_IR) || (st.tap == csp_pkg::SH_DR);
    end
    if (!trst_n_s) begin
      next_st.tap    = csp_pkg::TLR;
      next_st.tdo_oe = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pins.scl_d_o  = 1'b0;
  assign pins.scl_d_oe = st.scl_oe;
  assign pins.sda_d_o  = 1'b0;
  assign pins.sda_d_oe = st.sda_oe;
  assign pins.so_o     = st.so;
  assign pins.so_oe    = st.so_oe;
  assign pins.int_o    = 1'b0;
  assign pins.int_oe   = st.int_oe;
  assign pins.tdo_o    = st.tdo;
  assign pins.tdo_oe   = st.tdo_oe;
  assign pins.lock     = st.lock;
  assign pins.hold     = st.hold;

  assign dev_rst_o              = st.in_rst;
  assign dpll_mode_o            = st.mode;
  assign diff_drv_en_o          = st.diff_en;
  assign i2c_mode_o             = st.i2c;
  assign ser_clk_o              = st.ser_clk;
  assign ser_din_o              = st.ser_din;
  assign spi_cs_n_o             = st.cs_n;
  assign bus_address_bit_zero_o = st.addr0;
  assign apll_khz_o             = st.apll;
  assign pclk_khz_o             = st.pclk;
  assign fp_hz_o                = st.fp;
  assign fp_style_o             = st.style;

endmodule : sync_dev_pins

// >>> hw/sync_host_ctrl.sv
// Host controller end: AHB-Lite registers that drive the synchronizer's pins.
// Assumes one AHB-Lite master, single word transfers.
`timescale 1ns/1ps
module sync_host_ctrl #(
  parameter int RST_CYC = csp_pkg::RST_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  csp_if.host              pins
);

  logic [6:0] in_s;

  pin_sync3 #(
    .W    (7),
    .INIT (7'h78)
  ) u_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     ({pins.tdo, pins.sda, pins.scl, pins.so, ~pins.int_n, pins.hold, pins.lock}),
    .level_o   (in_s)
  );

  typedef struct packed {
    logic        dph;
    logic        wr;
    logic [3:0]  addr;
    logic        ready;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] pinr;
    logic [7:0]  rst_cnt;
    logic [7:0]  trst_cnt;
    logic        rst_n;
    logic        trst_n;
    logic        scl_o;
    logic        scl_oe;
    logic        sda_o;
    logic        sda_oe;
  } st_s;

  st_s st;
  st_s next_st;

  logic busy;
  assign busy = (st.rst_cnt != '0) || (st.trst_cnt != '0);

  always_comb begin
    next_st = st;
    if (st.rst_cnt != '0) begin
      next_st.rst_cnt = st.rst_cnt - 8'h01;
    end
    if (st.trst_cnt != '0) begin
      next_st.trst_cnt = st.trst_cnt - 8'h01;
    end
    if (st.dph) begin
      next_st.dph   = 1'b0;
      next_st.ready = 1'b1;
      next_st.rdata = '0;
      if (st.wr) begin
        if (st.addr == csp_pkg::CTRL_OFS) begin
          next_st.ctrl = {27'h0, 2'h0, hwdata_i[2:0]};
          if (hwdata_i[csp_pkg::C_RST]) begin
            next_st.rst_cnt = RST_CYC[7:0];
          end
          if (hwdata_i[csp_pkg::C_TRST]) begin
            next_st.trst_cnt = RST_CYC[7:0];
          end
        end else if (st.addr == csp_pkg::PINS_OFS) begin
          next_st.pinr = {26'h0, hwdata_i[5:0]};
        end
      end else begin
        unique case (st.addr)
          csp_pkg::CTRL_OFS: next_st.rdata = st.ctrl;
          csp_pkg::PINS_OFS: next_st.rdata = st.pinr;
          csp_pkg::STAT_OFS: next_st.rdata = {24'h0, busy, in_s};
          default:           next_st.rdata = '0;
        endcase
      end
    end else if (hsel_i && htrans_i[1] && hready_i) begin
      next_st.dph   = 1'b1;
      next_st.wr    = hwrite_i;
      next_st.addr  = haddr_i[3:0];
      next_st.ready = 1'b0;
    end
    next_st.rst_n  = (next_st.rst_cnt == 8'h00);
    next_st.trst_n = (next_st.trst_cnt == 8'h00);
    // SPI drives push-pull, I2C only pulls low
    next_st.scl_o  = ~next_st.ctrl[csp_pkg::C_I2C] & next_st.pinr[csp_pkg::P_SCK];
    next_st.scl_oe = ~(next_st.ctrl[csp_pkg::C_I2C] & next_st.pinr[csp_pkg::P_SCK]);
    next_st.sda_o  = ~next_st.ctrl[csp_pkg::C_I2C] & next_st.pinr[csp_pkg::P_SI];
    next_st.sda_oe = ~(next_st.ctrl[csp_pkg::C_I2C] & next_st.pinr[csp_pkg::P_SI]);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= '{dph: 1'b0, wr: 1'b0, addr: 4'h0, ready: 1'b1, rdata: 32'h0,
              ctrl: csp_pkg::CTRL_RESET, pinr: csp_pkg::PINS_RESET,
              rst_cnt: RST_CYC[7:0], trst_cnt: RST_CYC[7:0], rst_n: 1'b0, trst_n: 1'b0,
              scl_o: 1'b0, scl_oe: 1'b1, sda_o: 1'b0, sda_oe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  logic i2c;
  assign i2c = st.ctrl[csp_pkg::C_I2C];

  assign hreadyout_o = st.ready;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = st.rdata;

  assign pins.rst_n    = st.rst_n;
  assign pins.trst_n   = st.trst_n;
  assign pins.mode     = st.ctrl[csp_pkg::C_MODE];
  assign pins.diff_en  = st.ctrl[csp_pkg::C_DIFF];
  assign pins.i2c_en   = i2c;
  assign pins.sel      = st.pinr[csp_pkg::P_SEL];
  assign pins.tck      = st.pinr[csp_pkg::P_TCK];
  assign pins.tms      = st.pinr[csp_pkg::P_TMS];
  assign pins.tdi      = st.pinr[csp_pkg::P_TDI];
  assign pins.scl_h_o  = st.scl_o;
  assign pins.scl_h_oe = st.scl_oe;
  assign pins.sda_h_o  = st.sda_o;
  assign pins.sda_h_oe = st.sda_oe;

endmodule : sync_host_ctrl

// >>> tb/csp_assertions.sv
// Checker for the pin link between the host controller and the device end.
// Assumes every link signal is sampled on the shared system clock.
`timescale 1ns/1ps
module csp_assertions (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic rst_n,
  input wire logic trst_n,
  input wire logic i2c_en,
  input wire logic tck,
  input wire logic lock,
  input wire logic hold,
  input wire logic scl_d_oe,
  input wire logic sda_d_oe,
  input wire logic so_oe,
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic tdo_o,
  input wire logic tdo_oe
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  //////////////////////////////////////////////////////////////////////////////
  chk_rst_pulse_len:
    assert property ($fell(rst_n) |-> !rst_n [*8] ##1 !rst_n [*7])
    else $error("chip reset pulse shorter than 15 clocks");
  chk_trst_pulse_len:
    assert property ($fell(trst_n) |-> !trst_n [*8] ##1 !trst_n [*7])
    else $error("test reset pulse shorter than 15 clocks");
  chk_reset_quiet:
    assert property (!rst_n [*7] |-> !lock && !hold && !so_oe)
    else $error("device outputs active while in chip reset");
  chk_spi_no_drive:
    assert property (!i2c_en [*7] |-> !scl_d_oe && !sda_d_oe)
    else $error("serial clock or data driven in SPI mode");
  chk_i2c_so_off:
    assert property (i2c_en [*7] |-> !so_oe)
    else $error("serial output driven in I2C mode");
  chk_int_reset_off:
    assert property (!rst_n [*7] |-> !int_oe)
    else $error("interrupt line pulled while in chip reset");
  chk_trst_tdo_off:
    assert property (!trst_n [*7] |-> !tdo_oe)
    else $error("test data out driven during test reset");
  chk_tdo_fall_edge:
    assert property ($changed(tdo_o) && tdo_oe && $past(tdo_oe) |-> !$past(tck, 4))
    else $error("test data out changed away from a falling test clock");
  cov_chip_reset: cover property ($fell(rst_n));
  cov_scan_drive: cover property ($rose(tdo_oe));
  cov_int_pull: cover property ($rose(int_oe) && !int_o);
  cov_spi_out: cover property ($rose(so_oe));
endmodule : csp_assertions

// >>> tb/tb.sv
// Bench: host controller and device end joined through the pin interface.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
module tb;
  logic        mclk_i = 0, sys_rst_i = 1, hsel = 1, hwrite = 0, hready, hresp;
  logic        fl = 0, pl = 0, ho = 0, sc = 0, ir = 0, mw = 0, mv = 0, sdo = 0;
  logic        scl_lo = 0, sda_lo = 0, dev_rst, dmode, diff_on, i2c_m, sclk, sdin, cs_n, abit;
  logic        cw = 0, ce = 0;
  logic [1:0]  htrans = 2'h0, cs = 2'h0;
  logic [3:0]  sty;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, apll, pclk, fph, m_ctrl;
  logic [31:0] lfsr = 32'hc3153f29, cv = 32'h0;
  int          errors = 0, total_checks = 0, n;

  always #10 mclk_i = ~mclk_i;
  //////////////////////////////////////////////////////////////////////////////
  csp_if pins_if ();
  sync_host_ctrl sync_host_ctrl_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .pins(pins_if)
  );
  sync_dev_pins sync_dev_pins_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .pins(pins_if), .freq_lock_i(fl), .phase_lock_i(pl),
    .holdover_i(ho), .status_chg_i(sc), .isr_read_i(ir), .modesel_wr_i(mw), .modesel_val_i(mv),
    .ser_dout_i(sdo), .scl_low_i(scl_lo), .sda_low_i(sda_lo), .cfg_wr_i(cw), .cfg_sel_i(cs),
    .cfg_eth_i(ce), .cfg_val_i(cv), .dev_rst_o(dev_rst), .dpll_mode_o(dmode),
    .diff_drv_en_o(diff_on), .i2c_mode_o(i2c_m), .ser_clk_o(sclk), .ser_din_o(sdin),
    .spi_cs_n_o(cs_n), .bus_address_bit_zero_o(abit), .apll_khz_o(apll), .pclk_khz_o(pclk),
    .fp_hz_o(fph), .fp_style_o(sty)
  );
  csp_assertions csp_assertions_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .rst_n(pins_if.rst_n), .trst_n(pins_if.trst_n),
    .i2c_en(pins_if.i2c_en), .tck(pins_if.tck), .lock(pins_if.lock), .hold(pins_if.hold),
    .scl_d_oe(pins_if.scl_d_oe), .sda_d_oe(pins_if.sda_d_oe), .so_oe(pins_if.so_oe),
    .int_o(pins_if.int_o), .int_oe(pins_if.int_oe), .tdo_o(pins_if.tdo_o),
    .tdo_oe(pins_if.tdo_oe)
  );
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits for hready sampled high at a falling edge; read data taken there
  task automatic wait_rdy();
    logic ok;
    n = 0;
    do begin
      @(negedge mclk_i);
      ok = hready;
      rd = hrdata;
      @(posedge mclk_i);
      n++;
    end while (ok !== 1'b1 && n < 40);
    if (ok !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus

  task automatic settle();
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : settle

  task automatic cfg(input logic [1:0] s, input logic e, input logic [31:0] v);
    @(posedge mclk_i);
    cw <= 1'b1;
    cs <= s;
    ce <= e;
    cv <= v;
    @(posedge mclk_i);
    cw <= 1'b0;
    @(negedge mclk_i);
  endtask : cfg

  task automatic tck_step(input logic tms);
    bus(1'b1, 4'h4, 32'h23 | {27'h0, tms, 4'h0});
    repeat (4) @(posedge mclk_i);
    bus(1'b1, 4'h4, 32'h2b | {27'h0, tms, 4'h0});
    repeat (4) @(posedge mclk_i);
  endtask : tck_step
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    m_ctrl = 32'h6;
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    chk(dev_rst, 1'b1);
    repeat (30) @(posedge mclk_i);
    settle();
    chk(dev_rst, 1'b0);
    chk(dmode, 1'b0);
    chk(apll, 32'h12fc0);
    chk(pclk, 32'h800);
    chk(fph, 32'h1f40);
    chk(sty, 32'h0);
    cfg(2'h0, 1'b0, 32'd125000);
    chk(apll, 32'd77760);
    cfg(2'h0, 1'b1, 32'd125000);
    chk(apll, 32'd125000);
    cfg(2'h1, 1'b0, 32'd12);
    chk(pclk, 32'd2048);
    cfg(2'h1, 1'b0, 32'd2);
    chk(pclk, 32'd2);
    cfg(2'h2, 1'b0, 32'h0);
    chk(fph, 32'd8000);
    cfg(2'h3, 1'b0, 32'h5);
    chk(sty, 32'h5);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, m_ctrl);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h36);
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    // Chip reset with the mode pin high, then register and pin control
    m_ctrl = 32'h7;
    bus(1'b1, 4'h0, 32'hf);
    repeat (40) @(posedge mclk_i);
    settle();
    chk(dmode, 1'b1);
    chk(apll, 32'd77760);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, m_ctrl);
    @(posedge mclk_i);
    mw <= 1'b1;
    @(posedge mclk_i);
    mw <= 1'b0;
    settle();
    chk(dmode, 1'b0);
    bus(1'b1, 4'h0, 32'h6);
    bus(1'b1, 4'h0, 32'h7);
    settle();
    chk(dmode, 1'b1);
    // Strap and select in every combination, line pulls set with select
    for (int k = 0; k < 4; k++) begin
      m_ctrl = {29'h0, k[1], k[0], 1'b0};
      lfsr = next_rand(lfsr);
      bus(1'b1, 4'h0, m_ctrl);
      bus(1'b1, 4'h4, k[0] ? 32'h37 : 32'h33);
      @(posedge mclk_i);
      sdo <= lfsr[0];
      scl_lo <= k[0];
      sda_lo <= k[0];
      settle();
      chk(i2c_m, k[1]);
      chk(diff_on, k[0]);
      chk(cs_n, k[1] | k[0]);
      chk(abit, k[1] & k[0]);
      chk(sclk, !(k[1] & k[0]));
      chk(sdin, !(k[1] & k[0]));
      chk(pins_if.so, (k[1] | k[0]) ? 1'b1 : lfsr[0]);
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, m_ctrl);
    end
    repeat (20) begin
      lfsr = next_rand(lfsr);
      @(posedge mclk_i);
      fl <= lfsr[0];
      pl <= lfsr[1];
      ho <= lfsr[2];
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      chk(pins_if.lock, lfsr[0] & lfsr[1]);
      chk(pins_if.hold, lfsr[2]);
    end
    // Set, set against clear, clear
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk_i);
      sc <= (k < 2);
      ir <= (k > 0);
      @(posedge mclk_i);
      sc <= 1'b0;
      ir <= 1'b0;
      settle();
      chk(pins_if.int_n, k == 2);
    end
    // Walk to instruction shift, one shift, then test reset
    for (int k = 0; k < 6; k++) begin
      tck_step(k == 1 || k == 2);
    end
    bus(1'b1, 4'h4, 32'h23);
    settle();
    chk(pins_if.tdo, 1'b0);
    bus(1'b1, 4'h0, m_ctrl | 32'h10);
    settle();
    chk(pins_if.tdo, 1'b1);
    chk(hresp, 1'b0);
    end_of_test();
  end
endmodule : tb
